// *** design/asr_pkg.sv ***
// Shared constants for the amplifier status and spreading register bank
package asr_pkg;
   localparam int NUM_CH = 4;
   // Register byte addresses
   localparam logic [7:0] REG_CLIP_STATUS = 8'h24;
   localparam logic [7:0] REG_ILIM_STATUS = 8'h25;
   localparam logic [7:0] REG_MISC4       = 8'h26;
   localparam logic [7:0] REG_MISC5       = 8'h28;
   localparam logic [7:0] REG_SS1         = 8'h77;
   localparam logic [7:0] REG_SS2         = 8'h78;
   // Reset values
   localparam logic [7:0] RST_STATUS = 8'h00;
   localparam logic [7:0] RST_MISC4  = 8'h40;
   localparam logic [7:0] RST_MISC5  = 8'h0a;
   localparam logic [7:0] RST_SS1    = 8'h00;
   localparam logic [7:0] RST_SS2    = 8'h3f;
   // Field positions
   localparam int MISC4_SERIAL_CLOCK_PHASE_INVERT_BIT = 3;
   localparam int MISC5_BW_BIT       = 7;
   localparam int MISC5_DIV2_BIT     = 6;
   localparam int MISC5_PHASE_BIT    = 5;
   localparam int SS1_EN_BIT         = 7;
   // Reserved field contents kept by the host
   localparam logic [3:0] MISC4_RSVD = 4'h4;
   localparam logic [4:0] MISC5_RSVD = 5'h0a;
   // Clip window default, in full-duty PWM cycles
   localparam logic [7:0] CLIP_WINDOW_DEF = 8'h14;
   // Target address; value is arbitrary
   localparam logic [6:0] I2C_ADDR_DEF = 7'h6a;
   // Timing
   localparam int CLK_PERIOD_NS     = 5;
   localparam int SCL_MIN_PERIOD_NS = 2500;
   localparam int SCL_QTR_CYCLES    =
      (SCL_MIN_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
endpackage

// *** design/asr_i2c_if.sv ***
// Two-wire link between the register bank and its host
`timescale 1ns/1ps
interface asr_i2c_if;
   logic scl;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic sda;
   // Open-drain wire with pull-up
   assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));
   modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host (output scl, input sda, output host_sda_o,
                 output host_sda_oe);
endinterface

// *** design/asr_dev_regs.sv ***
// Device end: two-wire target with status flags and spreading controls
`timescale 1ns/1ps
module asr_dev_regs
   import asr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR    = I2C_ADDR_DEF,
   parameter logic [7:0] CLIP_WINDOW = CLIP_WINDOW_DEF
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_b_i,
   asr_i2c_if.dev           bus,
   input  wire logic [3:0]  pwm_cycle_i,
   input  wire logic [3:0]  full_duty_i,
   input  wire logic [3:0]  ilimit_i,
   input  wire logic        flag_clear_i,
   input  wire logic        clip_pin_sel_i,
   output logic             warn_o,
   output logic             fault_o,
   output logic             serial_clock_phase_invert_o,
   output logic [2:0]       highpass_corner_select_o,
   output logic             spreading_enable_o,
   output logic [6:0]       spreading_amplitude_o,
   output logic [6:0]       spreading_prediv_o,
   output logic [8:0]       spreading_center_div_o,
   output logic             spreading_bandwidth_select_o,
   output logic             spreading_post_divider_o,
   output logic             phase_select_o
);

   typedef enum logic [2:0] {
      DS_IDLE, DS_ADDR, DS_PTR, DS_WDAT, DS_RDAT
   } asr_dev_state_t;

   asr_dev_state_t state_reg;
   asr_dev_state_t state_next;
   logic [1:0]     scl_sync_reg;
   logic [1:0]     sda_sync_reg;
   logic           scl_d_reg;
   logic           sda_d_reg;
   logic [3:0]     bit_cnt_reg;
   logic [3:0]     bit_cnt_next;
   logic [7:0]     shift_reg;
   logic [7:0]     shift_next;
   logic [7:0]     ptr_reg;
   logic [7:0]     ptr_next;
   logic [7:0]     tx_reg;
   logic [7:0]     tx_next;
   logic           sda_oe_reg;
   logic           sda_oe_next;
   logic           wr_en;
   logic [7:0]     misc4_reg;
   logic [7:0]     misc5_reg;
   logic [7:0]     ss1_reg;
   logic [7:0]     ss2_reg;
   logic [3:0]     clip_flags_reg;
   logic [3:0]     ilim_flags_reg;
   logic [3:0]     clip_hit;
   logic [8:0]     center_div_reg;

   // Bus pins pass two flip-flops before use
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_d_reg    <= 1'b1;
         sda_d_reg    <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], bus.scl};
         sda_sync_reg <= {sda_sync_reg[0], bus.sda};
         scl_d_reg    <= scl_sync_reg[1];
         sda_d_reg    <= sda_sync_reg[1];
      end
   end

   wire scl_s      = scl_sync_reg[1];
   wire sda_s      = sda_sync_reg[1];
   wire scl_rise   = scl_s & ~scl_d_reg;
   wire scl_fall   = ~scl_s & scl_d_reg;
   wire start_det  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   wire stop_det   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
   wire byte_done  = (bit_cnt_reg == 4'd8);
   wire addr_match = (shift_reg[7:1] == DEV_ADDR);
   wire ack_own    = byte_done &&
                     ((state_reg == DS_PTR) || (state_reg == DS_WDAT) ||
                      ((state_reg == DS_ADDR) && addr_match));
   wire tx_bit     = tx_reg[3'(4'd7 - bit_cnt_reg)];

   // Read data mux; unmapped addresses read zero
   wire [7:0] rd_ptr  = (state_reg == DS_RDAT) ? ptr_reg + 8'd1 : ptr_reg;
   wire [7:0] rd_data =
      (rd_ptr == REG_CLIP_STATUS) ? {4'h0, clip_flags_reg} :
      (rd_ptr == REG_ILIM_STATUS) ? {4'h0, ilim_flags_reg} :
      (rd_ptr == REG_MISC4)       ? misc4_reg :
      (rd_ptr == REG_MISC5)       ? misc5_reg :
      (rd_ptr == REG_SS1)         ? ss1_reg :
      (rd_ptr == REG_SS2)         ? ss2_reg : 8'h00;

   always_comb begin
      state_next   = state_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_next   = shift_reg;
      ptr_next     = ptr_reg;
      tx_next      = tx_reg;
      sda_oe_next  = sda_oe_reg;
      wr_en        = 1'b0;
      if (stop_det) begin
         state_next  = DS_IDLE;
         sda_oe_next = 1'b0;
      end else if (start_det) begin
         state_next   = DS_ADDR;
         bit_cnt_next = 4'd0;
         sda_oe_next  = 1'b0;
      end else if (scl_rise) begin
         if (!byte_done) begin
            shift_next   = {shift_reg[6:0], sda_s};
            bit_cnt_next = bit_cnt_reg + 4'd1;
         end else begin
            bit_cnt_next = 4'd0;
            unique case (state_reg)
               DS_ADDR: begin
                  if (!addr_match) begin
                     state_next = DS_IDLE;
                  end else if (shift_reg[0]) begin
                     state_next = DS_RDAT;
                     tx_next    = rd_data;
                  end else begin
                     state_next = DS_PTR;
                  end
               end
               DS_PTR: begin
                  ptr_next   = shift_reg;
                  state_next = DS_WDAT;
               end
               DS_WDAT: begin
                  wr_en    = 1'b1;
                  ptr_next = ptr_reg + 8'd1;
               end
               DS_RDAT: begin
                  // Host NACK ends the read burst
                  if (sda_s) begin
                     state_next = DS_IDLE;
                  end else begin
                     ptr_next = ptr_reg + 8'd1;
                     tx_next  = rd_data;
                  end
               end
               DS_IDLE: begin
                  state_next = DS_IDLE;
               end
            endcase
         end
      end else if (scl_fall) begin
         if ((state_reg == DS_RDAT) && !byte_done) begin
            sda_oe_next = ~tx_bit;
         end else begin
            sda_oe_next = ack_own;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg   <= DS_IDLE;
         bit_cnt_reg <= 4'd0;
         shift_reg   <= 8'h00;
         ptr_reg     <= 8'h00;
         tx_reg      <= 8'h00;
         sda_oe_reg  <= 1'b0;
      end else begin
         state_reg   <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg   <= shift_next;
         ptr_reg     <= ptr_next;
         tx_reg      <= tx_next;
         sda_oe_reg  <= sda_oe_next;
      end
   end

   assign bus.dev_sda_o  = 1'b0;
   assign bus.dev_sda_oe = sda_oe_reg;

   // only control bytes decode a write
   wire wr_misc4 = wr_en && (ptr_reg == REG_MISC4);
   wire wr_misc5 = wr_en && (ptr_reg == REG_MISC5);
   wire wr_ss1   = wr_en && (ptr_reg == REG_SS1);
   wire wr_ss2   = wr_en && (ptr_reg == REG_SS2);

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         misc4_reg <= RST_MISC4;
         misc5_reg <= RST_MISC5;
         ss1_reg   <= RST_SS1;
         ss2_reg   <= RST_SS2;
      end else begin
         if (wr_misc4) misc4_reg <= shift_reg;
         if (wr_misc5) misc5_reg <= shift_reg;
         if (wr_ss1)   ss1_reg   <= shift_reg;
         if (wr_ss2)   ss2_reg   <= shift_reg;
      end
   end

   // Per-channel run of consecutive full-duty PWM cycles
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_clip
      logic [7:0] run_reg;
      wire  [7:0] run_inc = (run_reg == 8'hff) ? run_reg : run_reg + 8'd1;
      always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            run_reg <= 8'h00;
         end else if (pwm_cycle_i[ch]) begin
            run_reg <= full_duty_i[ch] ? run_inc : 8'h00;
         end
      end
      assign clip_hit[ch] = pwm_cycle_i[ch] && full_duty_i[ch] &&
                            (run_inc >= CLIP_WINDOW);
   end

   // Sticky flags; a new event beats a clear in the same cycle
   wire [3:0] clip_keep = flag_clear_i ? 4'h0 : clip_flags_reg;
   wire [3:0] ilim_keep = flag_clear_i ? 4'h0 : ilim_flags_reg;
   wire warn_next  = clip_pin_sel_i ? |clip_flags_reg[1:0] : |clip_flags_reg;
   wire fault_next = clip_pin_sel_i & |clip_flags_reg[3:2];
   wire [8:0] div_next = {1'b0, ss2_reg[6:0], 1'b0} + 9'd2;

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         clip_flags_reg <= RST_STATUS[3:0];
         ilim_flags_reg <= RST_STATUS[3:0];
         warn_o         <= 1'b0;
         fault_o        <= 1'b0;
         center_div_reg <= {1'b0, RST_SS2[6:0], 1'b0} + 9'd2;
      end else begin
         clip_flags_reg <= clip_hit | clip_keep;
         ilim_flags_reg <= ilimit_i | ilim_keep;
         warn_o         <= warn_next;
         fault_o        <= fault_next;
         center_div_reg <= div_next;
      end
   end

   assign serial_clock_phase_invert_o  = misc4_reg[MISC4_SERIAL_CLOCK_PHASE_INVERT_BIT];
   assign highpass_corner_select_o     = misc4_reg[2:0];
   assign spreading_enable_o           = ss1_reg[SS1_EN_BIT];
   assign spreading_amplitude_o        = ss1_reg[6:0];
   assign spreading_prediv_o           = ss2_reg[6:0];
   assign spreading_center_div_o       = center_div_reg;
   assign spreading_bandwidth_select_o = misc5_reg[MISC5_BW_BIT];
   assign spreading_post_divider_o     = misc5_reg[MISC5_DIV2_BIT];
   assign phase_select_o               = misc5_reg[MISC5_PHASE_BIT];

endmodule // asr_dev_regs

// *** design/asr_host_ctrl.sv ***
// Host end: two-wire controller issuing single-byte register accesses
`timescale 1ns/1ps
module asr_host_ctrl
   import asr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR   = I2C_ADDR_DEF,
   parameter int         QTR_CYCLES = SCL_QTR_CYCLES
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_b_i,
   asr_i2c_if.host          bus,
   input  wire logic        cmd_valid_i,
   input  wire logic        cmd_read_i,
   input  wire logic [7:0]  cmd_reg_i,
   input  wire logic [7:0]  cmd_wdata_i,
   input  wire logic        clocks_inverted_i,
   output logic             cmd_ready_o,
   output logic             rsp_valid_o,
   output logic [7:0]       rsp_data_o,
   output logic             rsp_nack_o
);

   typedef enum logic [1:0] {HK_START, HK_SEND, HK_RECV, HK_STOP} asr_kind_t;

   asr_kind_t   kind;
   logic [1:0]  sda_sync_reg;
   logic        busy_reg;
   logic        rd_reg;
   logic [7:0]  reg_reg;
   logic [7:0]  data_reg;
   logic [2:0]  step_reg;
   logic [3:0]  bit_reg;
   logic [1:0]  q_reg;
   logic [15:0] tick_reg;
   logic        nack_reg;
   logic        ss_en_reg;
   logic        scl_reg;
   logic        oe_reg;
   logic [7:0]  wdata_eff;

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) sda_sync_reg <= 2'h3;
      else          sda_sync_reg <= {sda_sync_reg[0], bus.sda};
   end
   wire sda_s = sda_sync_reg[1];

   // reserved fields rewritten at reset values
   always_comb begin
      unique case (cmd_reg_i)
         // inversion bit follows the clock relationship
         REG_MISC4: wdata_eff = {MISC4_RSVD, clocks_inverted_i,
                                 cmd_wdata_i[2:0]};
         REG_MISC5: wdata_eff = {ss_en_reg, ss_en_reg, 1'b1, MISC5_RSVD};
         REG_SS2:   wdata_eff = {1'b0, cmd_wdata_i[6:0]};
         default:   wdata_eff = cmd_wdata_i;
      endcase
   end

   wire [2:0] last_step = rd_reg ? 3'd6 : 3'd4;
   wire [7:0] tx_byte   = (step_reg == 3'd1) ? {DEV_ADDR, 1'b0} :
                          (step_reg == 3'd2) ? reg_reg :
                          (step_reg == 3'd3) ? data_reg :
                                               {DEV_ADDR, 1'b1};
   assign kind = (step_reg == last_step) ? HK_STOP :
                 ((step_reg == 3'd0) || (rd_reg && step_reg == 3'd3)) ?
                 HK_START :
                 (rd_reg && step_reg == 3'd5) ? HK_RECV : HK_SEND;

   wire tick      = busy_reg && (tick_reg == 16'(QTR_CYCLES - 1));
   wire sample    = tick && (q_reg == 2'd2);
   wire bit_kind  = (kind == HK_SEND) || (kind == HK_RECV);
   wire step_end  = tick && (q_reg == 2'd3) && (!bit_kind || bit_reg == 4'd8);
   wire nack_now  = sample && (kind == HK_SEND) && (bit_reg == 4'd8) && sda_s;
   wire tx_bit    = tx_byte[3'(4'd7 - bit_reg)];
   wire scl_hi    = (q_reg == 2'd1) || (q_reg == 2'd2);
   wire accept    = cmd_valid_i && cmd_ready_o;
   wire done      = step_end && (step_reg == last_step);

   wire scl_next = !busy_reg ? 1'b1 :
                   (kind == HK_STOP) ? (q_reg != 2'd0) : scl_hi;
   wire oe_next  = !busy_reg ? 1'b0 :
                   (kind == HK_START) ? q_reg[1] :
                   (kind == HK_STOP)  ? !q_reg[1] :
                   (kind == HK_SEND) && (bit_reg != 4'd8) && !tx_bit;

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy_reg    <= 1'b0;
         rd_reg      <= 1'b0;
         reg_reg     <= 8'h00;
         data_reg    <= 8'h00;
         step_reg    <= 3'd0;
         bit_reg     <= 4'd0;
         q_reg       <= 2'd0;
         tick_reg    <= 16'h0000;
         nack_reg    <= 1'b0;
         ss_en_reg   <= 1'b0;
         scl_reg     <= 1'b1;
         oe_reg      <= 1'b0;
         cmd_ready_o <= 1'b0;
         rsp_valid_o <= 1'b0;
         rsp_data_o  <= 8'h00;
         rsp_nack_o  <= 1'b0;
      end else begin
         scl_reg     <= scl_next;
         oe_reg      <= oe_next;
         rsp_valid_o <= done;
         cmd_ready_o <= !busy_reg && !accept;
         tick_reg    <= tick ? 16'h0000 : (busy_reg ? tick_reg + 16'd1 :
                                                       16'h0000);
         if (accept) begin
            busy_reg <= 1'b1;
            rd_reg   <= cmd_read_i;
            reg_reg  <= cmd_reg_i;
            data_reg <= wdata_eff;
            step_reg <= 3'd0;
            bit_reg  <= 4'd0;
            q_reg    <= 2'd0;
            nack_reg <= 1'b0;
            if (!cmd_read_i && cmd_reg_i == REG_SS1) begin
               ss_en_reg <= cmd_wdata_i[SS1_EN_BIT];
            end
         end
         if (nack_now) nack_reg <= 1'b1;
         if (sample && kind == HK_RECV && bit_reg != 4'd8) begin
            data_reg <= {data_reg[6:0], sda_s};
         end
         if (tick) begin
            q_reg <= q_reg + 2'd1;
            if (q_reg == 2'd3 && bit_kind) begin
               bit_reg <= (bit_reg == 4'd8) ? 4'd0 : bit_reg + 4'd1;
            end
         end
         if (step_end) begin
            step_reg <= nack_reg ? last_step : step_reg + 3'd1;
         end
         if (done) begin
            busy_reg   <= 1'b0;
            rsp_data_o <= rd_reg ? data_reg : 8'h00;
            rsp_nack_o <= nack_reg;
         end
      end
   end

   assign bus.scl         = scl_reg;
   assign bus.host_sda_o  = 1'b0;
   assign bus.host_sda_oe = oe_reg;

endmodule // asr_host_ctrl

// *** verif/asr_link_checker.sv ***
// Wire-level checks on the two-wire link between host and register bank
`timescale 1ns/1ps
module asr_link_checker (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic host_sda_o,
   input wire logic host_sda_oe
);
   logic [5:0] hi_reg;
   logic [5:0] hi_next;

   // Counts clock cycles of a steady high serial clock, saturating
   assign hi_next = !scl ? 6'h00 : (hi_reg == 6'h3f ? hi_reg : hi_reg + 6'h01);

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hi_reg <= 6'h00;
      end else begin
         hi_reg <= hi_next;
      end
   end

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);

   // Device moves its data line only while the serial clock is low
   a_dev_change_low: assert property ($changed(dev_sda_oe) |->
      !scl && !dev_sda_o)
      else $error("device data changed while clock is high");
   // Host must not fight the device on a clock rise it drives
   a_host_yields_dev: assert property ($rose(scl) && dev_sda_oe |->
      !host_sda_oe && !host_sda_o)
      else $error("host drives data while device answers");
   a_reset_bus_idle: assert property ($rose(rst_b_i) |->
      scl && !dev_sda_oe && !host_sda_oe)
      else $error("link not idle when reset is released");
   a_scl_high_min: assert property ($rose(scl) |-> scl[*8])
      else $error("serial clock high phase too short");
   a_scl_low_min: assert property ($fell(scl) |-> !scl[*8])
      else $error("serial clock low phase too short");
   a_dev_drive_low: assert property ($rose(dev_sda_oe) |-> !scl)
      else $error("device starts driving while clock is high");
   a_dev_drive_lead: assert property ($rose(dev_sda_oe) |->
      ##[1:16] $rose(scl))
      else $error("no clock rise soon after device drives");
   a_dev_stable_high: assert property (scl[*4] |-> $stable(dev_sda_oe))
      else $error("device data changed while clock is high");
   a_idle_released: assert property (hi_reg == 6'h3f |->
      sda && !dev_sda_oe)
      else $error("data line not released on an idle link");
endmodule // asr_link_checker

// *** verif/amp_status_and_spread_spectrum_regs_test.sv ***
// Testbench: host and device ends joined over the two-wire link
`timescale 1ns/1ps
module amp_status_and_spread_spectrum_regs_test import asr_pkg::*;;
   logic       clk_sys;
   logic       rst_b;
   logic       cmd_valid;
   logic       cmd_read;
   logic [7:0] cmd_reg;
   logic [7:0] cmd_wdata;
   logic       clk_inv;
   logic       cmd_ready;
   logic       rsp_valid;
   logic [7:0] rsp_data;
   logic       rsp_nack;
   logic [3:0] pwm;
   logic [3:0] full;
   logic [3:0] ilim;
   logic       clr;
   logic       pin_sel;
   logic       warn;
   logic       fault;
   logic       inv;
   logic [2:0] hpf;
   logic       ss_en;
   logic [6:0] amp;
   logic [6:0] prediv;
   logic [8:0] cdiv;
   logic       bw;
   logic       pdiv;
   logic       phase;
   int         fails;
   int         cmp_count;

   asr_i2c_if link_if ();

   asr_dev_regs asr_dev_regs_i (.clk_sys_i(clk_sys), .rst_b_i(rst_b),
      .bus(link_if.dev), .pwm_cycle_i(pwm), .full_duty_i(full),
      .ilimit_i(ilim), .flag_clear_i(clr), .clip_pin_sel_i(pin_sel),
      .warn_o(warn), .fault_o(fault), .serial_clock_phase_invert_o(inv),
      .highpass_corner_select_o(hpf), .spreading_enable_o(ss_en),
      .spreading_amplitude_o(amp), .spreading_prediv_o(prediv),
      .spreading_center_div_o(cdiv), .spreading_bandwidth_select_o(bw),
      .spreading_post_divider_o(pdiv), .phase_select_o(phase));

   asr_host_ctrl #(.QTR_CYCLES(8)) asr_host_ctrl_i (.clk_sys_i(clk_sys),
      .rst_b_i(rst_b), .bus(link_if.host), .cmd_valid_i(cmd_valid),
      .cmd_read_i(cmd_read), .cmd_reg_i(cmd_reg), .cmd_wdata_i(cmd_wdata),
      .clocks_inverted_i(clk_inv), .cmd_ready_o(cmd_ready),
      .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
      .rsp_nack_o(rsp_nack));

   asr_link_checker asr_link_checker_i (.clk_sys_i(clk_sys),
      .rst_b_i(rst_b), .scl(link_if.scl), .sda(link_if.sda),
      .dev_sda_o(link_if.dev_sda_o), .dev_sda_oe(link_if.dev_sda_oe),
      .host_sda_o(link_if.host_sda_o),
      .host_sda_oe(link_if.host_sda_oe));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic chk(input string nm, input logic [8:0] ex,
                      input logic [8:0] got);
      cmp_count++;
      if (got !== ex) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // One command through the host port, response taken at a settled point
   task automatic acc(input logic rd, input logic [7:0] ra,
                      input logic [7:0] wd, output logic [7:0] q);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 4000) begin
         @(negedge clk_sys);
         n++;
      end
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_read  <= rd;
      cmd_reg   <= ra;
      cmd_wdata <= wd;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (rsp_valid !== 1'b1 && n < 4000);
      q = rsp_data;
      chk("rsp_valid", 9'h001, 9'(rsp_valid));
      chk("rsp_nack", 9'h000, 9'(rsp_nack));
   endtask

   task automatic wr(input logic [7:0] ra, input logic [7:0] wd);
      logic [7:0] q;
      acc(1'b0, ra, wd, q);
   endtask

   task automatic rdc(input logic [7:0] ra, input logic [7:0] ex);
      logic [7:0] q;
      acc(1'b1, ra, 8'h00, q);
      chk($sformatf("reg %h", ra), 9'(ex), 9'(q));
   endtask

   task automatic pwm_run(input logic [3:0] fm, input int n);
      repeat (n) begin
         @(posedge clk_sys);
         pwm  <= 4'hf;
         full <= fm;
         @(posedge clk_sys);
         pwm  <= 4'h0;
      end
      repeat (3) @(negedge clk_sys);
   endtask

   task automatic clr_pulse;
      @(posedge clk_sys);
      clr <= 1'b1;
      @(posedge clk_sys);
      clr <= 1'b0;
      repeat (3) @(negedge clk_sys);
   endtask

   task automatic t_reset;
      chk("ss_en", 9'h000, 9'(ss_en));
      chk("amp", 9'h000, 9'(amp));
      chk("prediv", 9'h03f, 9'(prediv));
      chk("cdiv", 9'h080, cdiv);
      chk("warn", 9'h000, 9'(warn));
      chk("fault", 9'h000, 9'(fault));
      rdc(REG_CLIP_STATUS, RST_STATUS);
      rdc(REG_ILIM_STATUS, RST_STATUS);
      rdc(REG_MISC4, RST_MISC4);
      rdc(REG_MISC5, RST_MISC5);
      rdc(REG_SS1, RST_SS1);
      rdc(REG_SS2, RST_SS2);
   endtask

   task automatic t_misc4;
      for (int c = 0; c < 8; c++) begin
         @(posedge clk_sys);
         clk_inv <= c[0];
         wr(REG_MISC4, {4'h4, 1'b0, 3'(c)});
         chk("corner", 9'(c), 9'(hpf));
         chk("invert", 9'(c[0]), 9'(inv));
         rdc(REG_MISC4, {4'h4, c[0], 3'(c)});
      end
   endtask

   task automatic t_spread;
      wr(REG_SS1, 8'hd5);
      wr(REG_MISC5, 8'h00);
      chk("ss_en", 9'h001, 9'(ss_en));
      chk("amp", 9'h055, 9'(amp));
      chk("bw", 9'h001, 9'(bw));
      chk("pdiv", 9'h001, 9'(pdiv));
      chk("phase", 9'h001, 9'(phase));
      rdc(REG_MISC5, 8'hea);
      wr(REG_SS2, 8'h1f);
      chk("prediv", 9'h01f, 9'(prediv));
      chk("cdiv", 9'h040, cdiv);
      wr(REG_SS2, 8'h7f);
      chk("cdiv", 9'h100, cdiv);
      rdc(REG_SS2, 8'h7f);
      wr(REG_SS1, 8'h00);
      wr(REG_MISC5, 8'h00);
      chk("ss_en", 9'h000, 9'(ss_en));
      chk("bw", 9'h000, 9'(bw));
      chk("pdiv", 9'h000, 9'(pdiv));
      rdc(8'h30, 8'h00);
   endtask

   task automatic t_clip;
      @(posedge clk_sys);
      pin_sel <= 1'b1;
      pwm_run(4'h4, 19);
      pwm_run(4'h0, 1);
      pwm_run(4'h4, 19);
      chk("fault", 9'h000, 9'(fault));
      rdc(REG_CLIP_STATUS, 8'h00);
      pwm_run(4'h4, 1);
      chk("fault", 9'h001, 9'(fault));
      chk("warn", 9'h000, 9'(warn));
      rdc(REG_CLIP_STATUS, 8'h04);
      wr(REG_CLIP_STATUS, 8'h00);
      rdc(REG_CLIP_STATUS, 8'h04);
      @(posedge clk_sys);
      pin_sel <= 1'b0;
      repeat (3) @(negedge clk_sys);
      chk("warn", 9'h001, 9'(warn));
      chk("fault", 9'h000, 9'(fault));
      clr_pulse();
      chk("warn", 9'h000, 9'(warn));
      rdc(REG_CLIP_STATUS, 8'h00);
      // Channel 0 stays on the warning pin in split routing
      @(posedge clk_sys);
      pin_sel <= 1'b1;
      pwm_run(4'h1, 20);
      chk("warn", 9'h001, 9'(warn));
      chk("fault", 9'h000, 9'(fault));
      rdc(REG_CLIP_STATUS, 8'h01);
      clr_pulse();
   endtask

   task automatic t_ilim;
      @(posedge clk_sys);
      ilim <= 4'ha;
      @(posedge clk_sys);
      ilim <= 4'h0;
      rdc(REG_ILIM_STATUS, 8'h0a);
      wr(REG_ILIM_STATUS, 8'hff);
      rdc(REG_ILIM_STATUS, 8'h0a);
      clr_pulse();
      rdc(REG_ILIM_STATUS, 8'h00);
      // A new event in the clear cycle must survive
      @(posedge clk_sys);
      ilim <= 4'h1;
      clr  <= 1'b1;
      @(posedge clk_sys);
      ilim <= 4'h0;
      clr  <= 1'b0;
      rdc(REG_ILIM_STATUS, 8'h01);
      clr_pulse();
      rdc(REG_ILIM_STATUS, 8'h00);
   endtask

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge clk_sys);
      fails++;
      $display("[ERR] watchdog expected done seen running");
      end_sim();
   end

   initial begin
      fails = 0;
      cmp_count = 0;
      rst_b = 1'b0;
      {cmd_valid, cmd_read, cmd_reg, cmd_wdata, clk_inv} = '0;
      {pwm, full, ilim, clr, pin_sel} = '0;
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (2) @(negedge clk_sys);
      t_reset();
      t_misc4();
      t_spread();
      t_clip();
      t_ilim();
      end_sim();
   end
endmodule // amp_status_and_spread_spectrum_regs_test
